/* File: hdl/adc_fmt_defines.vh */
/*
 Register offsets, field positions and reset values for the converter result
 formatting and window compare block. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef ADC_FMT_DEFINES_VH
`define ADC_FMT_DEFINES_VH
`define OFF_RESULT_HIGH 12'h000
`define OFF_RESULT_LOW 12'h004
`define OFF_UPPER_HIGH 12'h008
`define OFF_UPPER_LOW 12'h00c
`define OFF_LOWER_HIGH 12'h010
`define OFF_LOWER_LOW 12'h014
`define OFF_CONTROL 12'h018
`define CTL_JUSTIFY_BIT 0
`define CTL_WIN_BIT 1
`define RST_LIMIT 8'h00
`define RST_RESULT 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: hdl/adc_result_format_window.v */
/*
 Result formatting and window compare back end of a 12-bit SAR converter,
 with an AXI4-Lite register slave. Assumes the analog core delivers one raw
 code with a one-cycle done strobe, on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_defines.vh"
// Operation
// - Justify clear: bits 11..8 in high byte low nibble, 7..0 low byte.
// - Right justified upper nibble: sign copies if differential, else zeros.
// - Justify set: result left justified, low byte low nibble zero.
// - Codes unsigned for single-ended, two's complement for differential.
// - Every result compared against limits in hardware, flag set on match.
// - Flag readable by software and available as an interrupt request.
// - Less-than above greater-than marks inside; swapped marks outside.
module adc_result_format_window #(
   parameter RES_W = 12
) (
   // Clock and reset
   input wire sys_clk_in,
   input wire resetn_in,
   // Converter core
   input wire [RES_W-1:0] conv_code_in,
   input wire conv_done_in,
   input wire differential_in,
   // Window flag request
   output wire window_irq_out,
   // AXI4-Lite write address
   input wire [11:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp_out,
   output wire s_axi_bvalid_out,
   input wire s_axi_bready_in,
   // AXI4-Lite read address
   input wire [11:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata_out,
   output wire [1:0] s_axi_rresp_out,
   output wire s_axi_rvalid_out,
   input wire s_axi_rready_in
);
   reg [7:0] result_high_byte_ff;
   reg [7:0] result_low_byte_ff;
   reg [7:0] upper_limit_high_byte_ff;
   reg [7:0] upper_limit_low_byte_ff;
   reg [7:0] lower_limit_high_byte_ff;
   reg [7:0] lower_limit_low_byte_ff;
   reg left_justify_select_ff;
   reg window_compare_flag_ff;
   reg nxt_window_compare_flag;
   reg aw_held_ff;
   reg [11:0] aw_addr_ff;
   reg w_held_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   reg bvalid_ff;
   reg [1:0] bresp_ff;
   reg rvalid_ff;
   reg [31:0] rdata_ff;
   reg [1:0] rresp_ff;
   wire [15:0] fmt_word;
   wire [15:0] gt_limit;
   wire [15:0] lt_limit;
   reg win_hit;
   reg above_gt;
   reg below_lt;
   reg lt_over_gt;
   wire do_write;
   wire wr_known;
   wire rd_known;
   wire flag_clear;

   // Decode shared by the read and write paths
   function known_offset;
      input [11:0] addr;
      begin
         case (addr)
            `OFF_RESULT_HIGH, `OFF_RESULT_LOW, `OFF_UPPER_HIGH, `OFF_UPPER_LOW,
            `OFF_LOWER_HIGH, `OFF_LOWER_LOW, `OFF_CONTROL: known_offset = 1'b1;
            default: known_offset = 1'b0;
         endcase
      end
   endfunction

   result_formatter #(
      .RES_W(RES_W)
   ) u_fmt (
      .raw_in(conv_code_in),
      .differential_in(differential_in),
      .left_justify_in(left_justify_select_ff),
      .word_out(fmt_word)
   );

   assign gt_limit = {upper_limit_high_byte_ff, upper_limit_low_byte_ff};
   assign lt_limit = {lower_limit_high_byte_ff, lower_limit_low_byte_ff};

   // Justified word compared, so limits are written in the same justification
   always @* begin
      if (differential_in) begin
         above_gt = $signed(fmt_word) > $signed(gt_limit);
         below_lt = $signed(fmt_word) < $signed(lt_limit);
         lt_over_gt = $signed(lt_limit) > $signed(gt_limit);
      end else begin
         above_gt = fmt_word > gt_limit;
         below_lt = fmt_word < lt_limit;
         lt_over_gt = lt_limit > gt_limit;
      end
      if (lt_over_gt) begin
         win_hit = above_gt & below_lt;
      end else begin
         win_hit = above_gt | below_lt;
      end
   end

   // Write channels may arrive in either order; each is held until both are in
   assign s_axi_awready_out = ~aw_held_ff & ~bvalid_ff;
   assign s_axi_wready_out = ~w_held_ff & ~bvalid_ff;
   assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign wr_known = known_offset(aw_addr_ff);
   assign flag_clear = do_write & (aw_addr_ff == `OFF_CONTROL) & w_strb_ff[0] &
                       ~w_data_ff[`CTL_WIN_BIT];

   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
         w_held_ff <= 1'b0;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata_in;
            w_strb_ff <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready_in) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Register stores; result bytes are read only
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         upper_limit_high_byte_ff <= `RST_LIMIT;
         upper_limit_low_byte_ff <= `RST_LIMIT;
         lower_limit_high_byte_ff <= `RST_LIMIT;
         lower_limit_low_byte_ff <= `RST_LIMIT;
         left_justify_select_ff <= 1'b0;
      end else if (do_write && w_strb_ff[0]) begin
         case (aw_addr_ff)
            `OFF_UPPER_HIGH: upper_limit_high_byte_ff <= w_data_ff[7:0];
            `OFF_UPPER_LOW: upper_limit_low_byte_ff <= w_data_ff[7:0];
            `OFF_LOWER_HIGH: lower_limit_high_byte_ff <= w_data_ff[7:0];
            `OFF_LOWER_LOW: lower_limit_low_byte_ff <= w_data_ff[7:0];
            `OFF_CONTROL: left_justify_select_ff <= w_data_ff[`CTL_JUSTIFY_BIT];
            default: left_justify_select_ff <= left_justify_select_ff;
         endcase
      end
   end

   // Next flag value; a hit in the clear cycle wins so no event is lost
   always @* begin
      nxt_window_compare_flag = window_compare_flag_ff;
      if (flag_clear) begin
         nxt_window_compare_flag = 1'b0;
      end
      if (conv_done_in && win_hit) begin
         nxt_window_compare_flag = 1'b1;
      end
   end

   // Result capture and window flag
   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         result_high_byte_ff <= `RST_RESULT;
         result_low_byte_ff <= `RST_RESULT;
         window_compare_flag_ff <= 1'b0;
      end else begin
         if (conv_done_in) begin
            result_high_byte_ff <= fmt_word[15:8];
            result_low_byte_ff <= fmt_word[7:0];
         end
         window_compare_flag_ff <= nxt_window_compare_flag;
      end
   end

   assign window_irq_out = window_compare_flag_ff;

   // Read channel: one read at a time, data registered
   assign s_axi_arready_out = ~rvalid_ff;
   assign rd_known = known_offset(s_axi_araddr_in);

   always @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
         case (s_axi_araddr_in)
            `OFF_RESULT_HIGH: rdata_ff <= {24'h000000, result_high_byte_ff};
            `OFF_RESULT_LOW: rdata_ff <= {24'h000000, result_low_byte_ff};
            `OFF_UPPER_HIGH: rdata_ff <= {24'h000000, upper_limit_high_byte_ff};
            `OFF_UPPER_LOW: rdata_ff <= {24'h000000, upper_limit_low_byte_ff};
            `OFF_LOWER_HIGH: rdata_ff <= {24'h000000, lower_limit_high_byte_ff};
            `OFF_LOWER_LOW: rdata_ff <= {24'h000000, lower_limit_low_byte_ff};
            `OFF_CONTROL: rdata_ff <= {30'h00000000, window_compare_flag_ff,
                                       left_justify_select_ff};
            default: rdata_ff <= 32'h00000000;
         endcase
      end else if (rvalid_ff && s_axi_rready_in) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign s_axi_rresp_out = rresp_ff;
endmodule // adc_result_format_window
`default_nettype wire

/* File: hdl/result_formatter.v */
/*
 Formats a raw converter code into the 16-bit data word.
 Assumes the raw code is stable while the done strobe is high.
*/
`timescale 1ns/1ps
`default_nettype none
module result_formatter #(
   parameter RES_W = 12
) (
   // Raw code and mode
   input wire [RES_W-1:0] raw_in,
   input wire differential_in,
   input wire left_justify_in,
   // Formatted word
   output reg [15:0] word_out
);
   always @* begin
      if (left_justify_in) begin
         // Low nibble forced to zero
         word_out = {raw_in, {(16-RES_W){1'b0}}};
      end else if (differential_in) begin
         // Sign copies make the word a two's-complement value
         word_out = {{(16-RES_W){raw_in[RES_W-1]}}, raw_in};
      end else begin
         word_out = {{(16-RES_W){1'b0}}, raw_in};
      end
   end
endmodule // result_formatter
`default_nettype wire

/* File: verification/adc_core_model.sv */
/* Model of the analog converter core.
   Assumes one request at a time from the bench, on the block's clock. */
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
   // Request from the bench
   input wire logic sys_clk_in,
   input wire logic start_in,
   input wire logic [11:0] code_in,
   input wire logic [3:0] lat_in,
   // Result towards the block
   output logic [11:0] code_out = 12'h000,
   output logic done_out = 1'b0
);
   logic [3:0] cnt_ff = 4'h0;
   logic [11:0] hold_ff = 12'h000;
   always @(posedge sys_clk_in) begin
      // Code is only valid with done; toggling exposes late sampling
      code_out <= ~code_out;
      done_out <= 1'b0;
      if (start_in) begin
         cnt_ff <= lat_in + 4'h1;
         hold_ff <= code_in;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
         if (cnt_ff == 4'h1) begin
            code_out <= hold_ff;
            done_out <= 1'b1;
         end
      end
   end
endmodule // adc_core_model
`default_nettype wire

/* File: verification/adc_result_format_window_chk.sv */
/* Port checker for the result and window block.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module adc_fmt_chk (
   // Clock, reset, converter
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic conv_done_in,
   input wire logic window_irq_out,
   // Register bus
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_ar;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   chk_read_answer: assert property (s_ar |=> s_axi_rvalid_out)
      else $error("read not answered");
   chk_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data moved");
   chk_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response moved");
   chk_write_block: assert property (s_axi_bvalid_out |->
      !s_axi_awready_out && !s_axi_wready_out) else $error("write taken early");
   chk_byte_wide: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_err_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out != 2'b00 |->
      s_axi_rdata_out == 32'h0) else $error("error read not zero");
   chk_flag_cause: assert property ($rose(window_irq_out) |-> $past(conv_done_in))
      else $error("flag set without conversion");
   chk_flag_sticky: assert property (window_irq_out |=>
      window_irq_out || $rose(s_axi_bvalid_out)) else $error("flag dropped");
endmodule // adc_fmt_chk
bind adc_result_format_window adc_fmt_chk u_chk (.sys_clk_in, .resetn_in, .conv_done_in,
   .window_irq_out, .s_axi_awready_out, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
   .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
   .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);
`default_nettype wire

/* File: verification/adc_result_format_window_tb_top.sv */
/* Bench for the result and window block.
   Assumes the converter model beside it and a 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_defines.vh"
module adc_result_format_window_tb_top;
   logic clk = 0, rstn = 0, st = 0, df = 0, ljst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [11:0] code = 0, aw = 0, ar = 0;
   logic [31:0] wd = 0;
   logic [3:0] lat = 0;
   wire logic [11:0] cc;
   wire logic [31:0] rd;
   wire logic [1:0] bresp, rresp;
   wire logic cd, awrdy, wrdy, bv, ardy, rv, irq;
   int n_mismatch = 0, comparisons = 0, cyc = 0;
   initial forever #10 clk = ~clk;
   adc_core_model core (.sys_clk_in(clk), .start_in(st), .code_in(code), .lat_in(lat),
      .code_out(cc), .done_out(cd));
   adc_result_format_window dut (.sys_clk_in(clk), .resetn_in(rstn), .conv_code_in(cc),
      .conv_done_in(cd), .differential_in(df), .window_irq_out(irq), .s_axi_awaddr_in(aw),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(ardy),
      .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task wrt(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awrdy) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (bv !== 1'b1);
      br <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      ar <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (ardy) arv <= 1'b0;
      end while (rv !== 1'b1);
      rr <= 1'b0;
      chk("rdata", e, rd);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask
   task cv(input logic [11:0] c, input logic d, input logic [15:0] w, input logic f);
      @(posedge clk);
      code <= c;
      df <= d;
      st <= 1'b1;
      @(posedge clk);
      st <= 1'b0;
      do @(posedge clk); while (cd !== 1'b1);
      @(negedge clk);
      chk("flag", {31'h0, f}, {31'h0, irq});
      rdc(12'h000, {24'h0, w[15:8]}, 2'b00);
      rdc(12'h004, {24'h0, w[7:0]}, 2'b00);
      rdc(`OFF_CONTROL, {30'h0, f, ljst}, 2'b00);
   endtask
   task clr;
      wrt(`OFF_CONTROL, {31'h0, ljst}, 2'b00);
      chk("flag", 32'h0, {31'h0, irq});
   endtask
   task lim(input logic [15:0] g, input logic [15:0] l);
      wrt(12'h008, {24'h0, g[15:8]}, 2'b00);
      wrt(12'h00c, {24'h0, g[7:0]}, 2'b00);
      wrt(12'h010, {24'h0, l[15:8]}, 2'b00);
      wrt(12'h014, {24'h0, l[7:0]}, 2'b00);
   endtask
   task test_done;
      $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Generous ceiling; the sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rdc(12'(i * 4), 32'h0, 2'b00);
      rdc(12'h01c, 32'h0, `RESP_SLVERR);
      wrt(12'h01c, 32'h1, `RESP_SLVERR);
      wrt(12'h000, 32'h55, 2'b00);
      rdc(12'h000, 32'h0, 2'b00);
      lim(16'h0100, 16'h0200);
      rdc(12'h010, 32'h2, 2'b00);
      cv(12'habc, 0, 16'h0abc, 0);
      cv(12'h800, 1, 16'hf800, 0);
      cv(12'h150, 0, 16'h0150, 1);
      lat <= 4'h9;
      cv(12'h200, 0, 16'h0200, 1);
      clr;
      cv(12'h100, 0, 16'h0100, 0);
      lim(16'h0200, 16'h0100);
      cv(12'h050, 0, 16'h0050, 1);
      clr;
      cv(12'h150, 0, 16'h0150, 0);
      lim(16'h0100, 16'hffff);
      cv(12'hfff, 1, 16'hffff, 0);
      cv(12'hffe, 1, 16'hfffe, 1);
      clr;
      ljst = 1'b1;
      wrt(`OFF_CONTROL, 32'h1, 2'b00);
      cv(12'habc, 0, 16'habc0, 1);
      wrt(`OFF_CONTROL, 32'h3, 2'b00);
      chk("flag", 32'h1, {31'h0, irq});
      clr;
      cv(12'h800, 1, 16'h8000, 1);
      test_done;
   end
endmodule // adc_result_format_window_tb_top
`default_nettype wire
